// ==== hdl/banked_mem_pkg.sv ====
package banked_mem_pkg;
   localparam int ADDR_W      = 12;
   localparam int OFS_W       = 7;
   localparam int BANK_W      = 5;
   localparam int PM_W        = 14;
   localparam int PM_ADDR_W   = 15;
   localparam int GPR_BYTES   = 80;
   localparam int COMMON_BYTES = 16;
   localparam logic [6:0] OFS_INDIRECT_DATA_ZERO   = 7'h00;
   localparam logic [6:0] OFS_INDIRECT_DATA_ONE   = 7'h01;
   localparam logic [6:0] OFS_PCL     = 7'h02;
   localparam logic [6:0] OFS_FLAGS   = 7'h03;
   localparam logic [6:0] OFS_P0L     = 7'h04;
   localparam logic [6:0] OFS_P0H     = 7'h05;
   localparam logic [6:0] OFS_P1L     = 7'h06;
   localparam logic [6:0] OFS_P1H     = 7'h07;
   localparam logic [6:0] OFS_BSEL    = 7'h08;
   localparam logic [6:0] OFS_ACC     = 7'h09;
   localparam logic [6:0] OFS_PROGRAM_COUNTER_LATCH_HIGH  = 7'h0A;
   localparam logic [6:0] OFS_INTCTL  = 7'h0B;
   localparam logic [6:0] OFS_SFR_LO  = 7'h0C;
   localparam logic [6:0] OFS_SFR_HI  = 7'h1F;
   localparam logic [6:0] OFS_GPR_LO  = 7'h20;
   localparam logic [6:0] OFS_GPR_HI  = 7'h6F;
   localparam logic [6:0] OFS_COM_LO  = 7'h70;
   localparam int BIT_EXPIRY = 4;
   localparam int BIT_SLEEP  = 3;
   localparam int BIT_ZERO   = 2;
   localparam int BIT_NIB    = 1;
   localparam int BIT_CARRY  = 0;
   localparam logic [7:0] FLAGS_RST = 8'h18;
   localparam logic [7:0] REG_RST   = 8'h00;
   localparam int PTR_PM_BIT = 7;
   localparam int PM_WAIT_CYCLES = 1;

   typedef enum logic [2:0] {
      ALU_NONE, ALU_ADD, ALU_SUB, ALU_LOGIC
   } alu_op_e;

   typedef struct packed {
      logic        valid;
      logic        wr;
      logic        indirect;
      logic        ptr_sel;
      logic [6:0]  ofs;
      logic [7:0]  wdata;
      alu_op_e     op;
      logic [7:0]  opa;
      logic [7:0]  opb;
   } mem_req_s;
endpackage

// ==== hdl/banked_data_memory_status.sv ====
`timescale 1ns/10ps
`default_nettype none
module banked_data_memory_status
   import banked_mem_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              por_event,
   input  wire mem_req_s          req,
   input  wire logic              watchdog_clear_instruction,
   input  wire logic              sleep_instruction,
   input  wire logic              watchdog_timeout,
   input  wire logic [PM_W-1:0]   pm_rdata,
   input  wire logic [7:0]        sfr_rdata,
   output logic [PM_ADDR_W-1:0]   pm_addr_q,
   output logic                   pm_rd_q,
   output logic [ADDR_W-1:0]      sfr_addr_q,
   output logic                   sfr_wr_q,
   output logic                   sfr_rd_q,
   output logic [7:0]             sfr_wdata_q,
   output logic [7:0]             rdata_q,
   output logic                   rvalid_q,
   output logic                   busy_q,
   output logic [7:0]             flags_q,
   output logic [7:0]             bank_select_q,
   output logic [7:0]             accumulator_q
);
   logic [7:0] p0l_q, p0h_q, p1l_q, p1h_q, pcl_q, program_counter_latch_high_q, intctl_q;
   logic [7:0] gpr_q [0:(1<<BANK_W)*GPR_BYTES-1];
   logic [7:0] com_q [0:COMMON_BYTES-1];

   wire logic [7:0]  ptr_hi   = req.ptr_sel ? p1h_q : p0h_q;
   wire logic [7:0]  ptr_lo   = req.ptr_sel ? p1l_q : p0l_q;
   wire logic        ptr_pm   = req.indirect && ptr_hi[PTR_PM_BIT];
   wire logic [ADDR_W-1:0] addr = req.indirect ? {ptr_hi[4:0], ptr_lo[6:0]}
                                 : {bank_select_q[BANK_W-1:0], req.ofs};
   wire logic [BANK_W-1:0] bank = addr[ADDR_W-1:OFS_W];
   wire logic [OFS_W-1:0]  ofs  = addr[OFS_W-1:0];
   wire logic is_core = ofs <= OFS_INTCTL;
   wire logic is_sfr  = ofs >= OFS_SFR_LO && ofs <= OFS_SFR_HI;
   wire logic is_gpr  = ofs >= OFS_GPR_LO && ofs <= OFS_GPR_HI;
   wire logic is_com  = ofs >= OFS_COM_LO;
   wire logic [6:0] gpr_ofs = 7'(ofs - OFS_GPR_LO);
   wire logic [11:0] gpr_idx = 12'(bank * GPR_BYTES + gpr_ofs);
   wire logic [3:0]  com_idx = ofs[3:0];
   wire logic go      = req.valid && !busy_q;
   wire logic dm_wr   = go && req.wr && !ptr_pm;
   wire logic dm_rd   = go && !req.wr && !ptr_pm;

   // arithmetic
   wire logic       cin     = req.op == ALU_SUB;
   wire logic [7:0] opb_eff = cin ? ~req.opb : req.opb;
   wire logic [8:0] sum     = {1'b0, req.opa} + {1'b0, opb_eff} + {8'h00, cin};
   wire logic [4:0] nsum    = {1'b0, req.opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
   wire logic       carry   = sum[8];
   wire logic       ncarry  = nsum[4];
   wire logic       arith   = req.op == ALU_ADD || req.op == ALU_SUB;
   wire logic       updz    = go && req.op != ALU_NONE;
   wire logic [7:0] result  = (req.op == ALU_LOGIC) ? req.wdata : sum[7:0];
   wire logic       zero    = result == 8'h00;

   // core register read mux
   logic [7:0] core_rd;
   always_comb begin
      case (ofs)
         OFS_PCL:    core_rd = pcl_q;
         OFS_FLAGS:  core_rd = {3'b000, flags_q[4:0]};
         OFS_P0L:    core_rd = p0l_q;
         OFS_P0H:    core_rd = p0h_q;
         OFS_P1L:    core_rd = p1l_q;
         OFS_P1H:    core_rd = p1h_q;
         OFS_BSEL:   core_rd = bank_select_q;
         OFS_ACC:    core_rd = accumulator_q;
         OFS_PROGRAM_COUNTER_LATCH_HIGH: core_rd = program_counter_latch_high_q;
         OFS_INTCTL: core_rd = intctl_q;
         default:    core_rd = 8'h00;
      endcase
   end
   wire logic [7:0] dm_rdata = is_core ? core_rd : is_gpr ? gpr_q[gpr_idx]
                             : is_com ? com_q[com_idx] : 8'h00;
   wire logic wr_core = dm_wr && is_core;

   // flag register next value
   logic [7:0] flags_d;
   always_comb begin
      flags_d = flags_q;
      if (wr_core && ofs == OFS_FLAGS)
         flags_d[2:0] = req.wdata[2:0];
      if (updz) begin
         flags_d[BIT_ZERO] = zero;
         if (arith) begin
            flags_d[BIT_NIB]   = ncarry;
            flags_d[BIT_CARRY] = carry;
         end
      end
      if (watchdog_clear_instruction) begin
         flags_d[BIT_EXPIRY] = 1'b1;
         flags_d[BIT_SLEEP]  = 1'b1;
      end
      if (sleep_instruction) begin
         flags_d[BIT_EXPIRY] = 1'b1;
         flags_d[BIT_SLEEP]  = 1'b0;
      end
      if (watchdog_timeout)
         flags_d[BIT_EXPIRY] = 1'b0;
      flags_d[7:5] = 3'b000;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_q <= FLAGS_RST;
      end else if (por_event) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         p0l_q <= REG_RST;
         p0h_q <= REG_RST;
         p1l_q <= REG_RST;
         p1h_q <= REG_RST;
         pcl_q <= REG_RST;
         program_counter_latch_high_q <= REG_RST;
         intctl_q <= REG_RST;
         bank_select_q <= REG_RST;
         accumulator_q <= REG_RST;
      end else begin
         if (wr_core && ofs == OFS_P0L) p0l_q <= req.wdata;
         if (wr_core && ofs == OFS_P0H) p0h_q <= req.wdata;
         if (wr_core && ofs == OFS_P1L) p1l_q <= req.wdata;
         if (wr_core && ofs == OFS_P1H) p1h_q <= req.wdata;
         if (wr_core && ofs == OFS_PCL) pcl_q <= req.wdata;
         if (wr_core && ofs == OFS_PROGRAM_COUNTER_LATCH_HIGH) program_counter_latch_high_q <= req.wdata;
         if (wr_core && ofs == OFS_INTCTL) intctl_q <= req.wdata;
         if (wr_core && ofs == OFS_BSEL) bank_select_q <= {3'b000, req.wdata[4:0]};
         if (wr_core && ofs == OFS_ACC) begin
            accumulator_q <= req.wdata;
         end else if (pm_rd_q) begin
            accumulator_q <= pm_rdata[7:0];
         end else if (dm_rd && req.indirect) begin
            accumulator_q <= is_sfr ? sfr_rdata : dm_rdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (dm_wr && is_gpr) gpr_q[gpr_idx] <= req.wdata;
      if (dm_wr && is_com) com_q[com_idx] <= req.wdata;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pm_addr_q <= '0;
         pm_rd_q <= 1'b0;
         busy_q <= 1'b0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         sfr_addr_q <= '0;
         sfr_wr_q <= 1'b0;
         sfr_rd_q <= 1'b0;
         sfr_wdata_q <= 8'h00;
      end else begin
         pm_rd_q <= go && !req.wr && ptr_pm;
         busy_q <= go && ptr_pm && !req.wr;
         if (go && ptr_pm) pm_addr_q <= {ptr_hi[6:0], ptr_lo};
         sfr_wr_q <= dm_wr && is_sfr;
         sfr_rd_q <= dm_rd && is_sfr;
         sfr_addr_q <= addr;
         sfr_wdata_q <= req.wdata;
         rvalid_q <= (dm_rd && !is_sfr) || pm_rd_q;
         if (pm_rd_q) rdata_q <= pm_rdata[7:0];
         else if (dm_rd) rdata_q <= dm_rdata;
      end
   end

   property p_pm_extra;
      @(posedge clk) disable iff (!nrst)
         (go && !req.wr && ptr_pm) |=> busy_q ##1 rvalid_q;
   endproperty
   a_pm_extra: assert property (p_pm_extra) else $error("pm read not one extra cycle");

   property p_upper_zero;
      @(posedge clk) disable iff (!nrst) flags_q[7:5] == 3'b000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("flag upper bits set");

   property p_sleep_clr;
      @(posedge clk) disable iff (!nrst)
         (sleep_instruction && !watchdog_clear_instruction && !por_event)
            |=> !flags_q[BIT_SLEEP];
   endproperty
   a_sleep_clr: assert property (p_sleep_clr) else $error("sleep bit not cleared");

   property p_timeout;
      @(posedge clk) disable iff (!nrst)
         (watchdog_timeout && !por_event) |=> !flags_q[BIT_EXPIRY];
   endproperty
   a_timeout: assert property (p_timeout) else $error("expiry bit not cleared");

   property p_wdclr;
      @(posedge clk) disable iff (!nrst)
         (watchdog_clear_instruction && !watchdog_timeout && !sleep_instruction)
            |=> flags_q[BIT_EXPIRY] && flags_q[BIT_SLEEP];
   endproperty
   a_wdclr: assert property (p_wdclr) else $error("watchdog clear missed");

   property p_zero;
      @(posedge clk) disable iff (!nrst)
         (updz && !por_event) |=> flags_q[BIT_ZERO] == $past(zero);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_bits_locked;
      @(posedge clk) disable iff (!nrst)
         (!watchdog_clear_instruction && !sleep_instruction && !watchdog_timeout
          && !por_event) |=> $stable(flags_q[4:3]);
   endproperty
   a_bits_locked: assert property (p_bits_locked) else $error("status bit written");

   property p_pm_no_write;
      @(posedge clk) disable iff (!nrst)
         (go && req.wr && ptr_pm) |=> !sfr_wr_q;
   endproperty
   a_pm_no_write: assert property (p_pm_no_write) else $error("pm write leaked");

   property p_por;
      @(posedge clk) disable iff (!nrst) por_event |=> flags_q == FLAGS_RST;
   endproperty
   a_por: assert property (p_por) else $error("power-on flags wrong");

   property p_pm_addr;
      @(posedge clk) disable iff (!nrst)
         (go && !req.wr && ptr_pm)
            |=> pm_rd_q && pm_addr_q == $past({ptr_hi[6:0], ptr_lo});
   endproperty
   a_pm_addr: assert property (p_pm_addr) else $error("pm address wrong");

   property p_pm_byte;
      @(posedge clk) disable iff (!nrst)
         pm_rd_q
            |=> rvalid_q && rdata_q == $past(pm_rdata[7:0]);
   endproperty
   a_pm_byte: assert property (p_pm_byte) else $error("pm byte not returned");

   property p_pm_acc;
      @(posedge clk) disable iff (!nrst)
         pm_rd_q
            |=> accumulator_q == $past(pm_rdata[7:0]);
   endproperty
   a_pm_acc: assert property (p_pm_acc) else $error("pm byte not in accumulator");

   property p_busy_refuse;
      @(posedge clk) disable iff (!nrst)
         busy_q
            |=> !busy_q && !pm_rd_q && !sfr_wr_q && !sfr_rd_q;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while busy");

   property p_dm_one;
      @(posedge clk) disable iff (!nrst)
         (dm_rd && !is_sfr)
            |=> rvalid_q && !busy_q;
   endproperty
   a_dm_one: assert property (p_dm_one) else $error("data read not one cycle");

   property p_bank_bits;
      @(posedge clk) disable iff (!nrst)
         1'b1
            |-> bank_select_q[7:5] == 3'b000;
   endproperty
   a_bank_bits: assert property (p_bank_bits) else $error("bank beyond 32");

   property p_bsel_write;
      @(posedge clk) disable iff (!nrst)
         (wr_core && ofs == OFS_BSEL)
            |=> bank_select_q == {3'b000, $past(req.wdata[4:0])};
   endproperty
   a_bsel_write: assert property (p_bsel_write) else $error("bank select not stored");

   property p_direct_addr;
      @(posedge clk) disable iff (!nrst)
         (dm_rd && is_sfr && !req.indirect)
            |=> sfr_addr_q == {$past(bank_select_q[BANK_W-1:0]), $past(req.ofs)};
   endproperty
   a_direct_addr: assert property (p_direct_addr) else $error("direct address wrong");

   property p_sfr_rd;
      @(posedge clk) disable iff (!nrst)
         (dm_rd && is_sfr)
            |=> sfr_rd_q && !rvalid_q;
   endproperty
   a_sfr_rd: assert property (p_sfr_rd) else $error("peripheral read missed");

   property p_sfr_wr;
      @(posedge clk) disable iff (!nrst)
         (dm_wr && is_sfr)
            |=> sfr_wr_q && sfr_wdata_q == $past(req.wdata);
   endproperty
   a_sfr_wr: assert property (p_sfr_wr) else $error("peripheral write missed");

   property p_no_sfr;
      @(posedge clk) disable iff (!nrst)
         (go && !is_sfr)
            |=> !sfr_wr_q && !sfr_rd_q;
   endproperty
   a_no_sfr: assert property (p_no_sfr) else $error("stray peripheral strobe");

   property p_add_nib;
      @(posedge clk) disable iff (!nrst)
         (go && req.op == ALU_ADD && !por_event)
            |=> flags_q[BIT_NIB] == $past({1'b0, req.opa[3:0]} + {1'b0, req.opb[3:0]} > 5'h0F);
   endproperty
   a_add_nib: assert property (p_add_nib) else $error("add nibble carry wrong");

   property p_add_carry;
      @(posedge clk) disable iff (!nrst)
         (go && req.op == ALU_ADD && !por_event)
            |=> flags_q[BIT_CARRY] == $past({1'b0, req.opa} + {1'b0, req.opb} > 9'h0FF);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

   property p_sub_carry;
      @(posedge clk) disable iff (!nrst)
         (go && req.op == ALU_SUB && !por_event)
            |=> flags_q[BIT_CARRY] == $past(req.opa >= req.opb);
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("sub borrow wrong");

   property p_sub_nib;
      @(posedge clk) disable iff (!nrst)
         (go && req.op == ALU_SUB && !por_event)
            |=> flags_q[BIT_NIB] == $past(req.opa[3:0] >= req.opb[3:0]);
   endproperty
   a_sub_nib: assert property (p_sub_nib) else $error("sub nibble borrow wrong");

   property p_result_wins;
      @(posedge clk) disable iff (!nrst)
         (wr_core && ofs == OFS_FLAGS && req.op == ALU_ADD && !por_event)
            |=> flags_q[BIT_CARRY] == $past({1'b0, req.opa} + {1'b0, req.opb} > 9'h0FF);
   endproperty
   a_result_wins: assert property (p_result_wins) else $error("write beat result");

   property p_logic_keeps;
      @(posedge clk) disable iff (!nrst)
         (go && req.op == ALU_LOGIC && !(wr_core && ofs == OFS_FLAGS) && !por_event)
            |=> $stable(flags_q[1:0]);
   endproperty
   a_logic_keeps: assert property (p_logic_keeps) else $error("logic op moved carries");

   property p_acc_read;
      @(posedge clk) disable iff (!nrst)
         (dm_rd && ofs == OFS_ACC)
            |=> rdata_q == $past(accumulator_q);
   endproperty
   a_acc_read: assert property (p_acc_read) else $error("accumulator mirror wrong");

   property p_flags_read;
      @(posedge clk) disable iff (!nrst)
         (dm_rd && ofs == OFS_FLAGS)
            |=> rdata_q == {3'b000, $past(flags_q[4:0])};
   endproperty
   a_flags_read: assert property (p_flags_read) else $error("flag mirror wrong");

   property p_gpr_read;
      @(posedge clk) disable iff (!nrst)
         (dm_rd && is_gpr)
            |=> rvalid_q && !sfr_rd_q;
   endproperty
   a_gpr_read: assert property (p_gpr_read) else $error("general ram read lost");

   property p_pm_write_quiet;
      @(posedge clk) disable iff (!nrst)
         (go && req.wr && ptr_pm)
            |=> !pm_rd_q && !busy_q && !rvalid_q;
   endproperty
   a_pm_write_quiet: assert property (p_pm_write_quiet) else $error("pm write acted");
endmodule
`default_nettype wire

// ==== test/banked_data_memory_status_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module banked_data_memory_status_tb_top
   import banked_mem_pkg::*;
;
   logic                 clk;
   logic                 nrst;
   logic [3:0]           ev;
   mem_req_s             req;
   logic [7:0]           sfr_rdata;
   wire  [PM_W-1:0]      pm_rdata;
   logic [PM_ADDR_W-1:0] pm_addr_q;
   logic [ADDR_W-1:0]    sfr_addr_q;
   logic [7:0]           sfr_wdata_q, rdata_q, flags_q, bank_select_q, accumulator_q;
   logic                 pm_rd_q, sfr_wr_q, sfr_rd_q, rvalid_q, busy_q;
   int                   errors, check_count;
   integer               seed = 32'h49E0;
   logic [7:0]           rq[$];
   logic [20:0]          sq[$];
   logic [7:0]           fl, dv[8], hi, lo, ta[5], tv[5];
   logic [4:0]           bank, bk[8];
   logic [13:0]          pw;
   alu_op_e              to[5];

   function automatic logic [13:0] pm_word(input logic [14:0] a);
      return a[13:0] ^ 14'h2A5C;
   endfunction
   assign pm_rdata = pm_word(pm_addr_q);

   banked_data_memory_status i_banked_data_memory_status (
      .clk(clk), .nrst(nrst), .por_event(ev[3]), .req(req),
      .watchdog_clear_instruction(ev[2]), .sleep_instruction(ev[1]),
      .watchdog_timeout(ev[0]), .pm_rdata(pm_rdata), .sfr_rdata(sfr_rdata),
      .pm_addr_q(pm_addr_q), .pm_rd_q(pm_rd_q), .sfr_addr_q(sfr_addr_q),
      .sfr_wr_q(sfr_wr_q), .sfr_rd_q(sfr_rd_q), .sfr_wdata_q(sfr_wdata_q),
      .rdata_q(rdata_q), .rvalid_q(rvalid_q), .busy_q(busy_q), .flags_q(flags_q),
      .bank_select_q(bank_select_q), .accumulator_q(accumulator_q));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // result watcher: oldest note against each answer
   always @(posedge clk) begin
      sfr_rdata <= 8'($random(seed));
      if (rvalid_q === 1'b1) begin
         if (rq.size() == 0) chk(21'h1, 21'h0, "unexpected read");
         else chk(21'(rdata_q), 21'(rq.pop_front()), "read data");
      end
      if (sfr_rd_q === 1'b1 || sfr_wr_q === 1'b1) begin
         if (sq.size() == 0) chk(21'h1, 21'h0, "unexpected peripheral");
         else chk({sfr_wr_q, sfr_addr_q, sfr_wr_q ? sfr_wdata_q : 8'h00}, sq.pop_front(), "periph");
      end
   end

   task automatic acc(input logic w, input logic ind, input logic ps, input logic [6:0] o,
                      input logic [7:0] wd, input alu_op_e al = ALU_NONE,
                      input logic [7:0] a = 8'h00, input logic [7:0] b = 8'h00);
      if (!ind && o >= OFS_SFR_LO && o <= OFS_SFR_HI) sq.push_back({w, bank, o, w ? wd : 8'h00});
      if (!ind && w && o == OFS_BSEL) bank = wd[4:0];
      req <= '{valid:1'b1, wr:w, indirect:ind, ptr_sel:ps, ofs:o, wdata:wd, op:al, opa:a, opb:b};
      @(posedge clk);
   endtask

   task automatic rd(input logic [6:0] o, input logic [7:0] e);
      rq.push_back(e);
      acc(1'b0, 1'b0, 1'b0, o, 8'h00);
   endtask

   task automatic pulse(input logic [3:0] m);
      req <= '0;
      ev <= m;
      @(posedge clk);
      ev <= 4'h0;
      @(posedge clk);
   endtask

   function automatic logic [7:0] alu(input logic [7:0] f, input alu_op_e al,
                                      input logic [7:0] a, input logic [7:0] b);
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] n;
      bb = (al == ALU_SUB) ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, al == ALU_SUB};
      n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, al == ALU_SUB};
      if (al == ALU_LOGIC) return {f[7:3], 1'b1, f[1:0]};
      return {f[7:3], s[7:0] == 8'h00, n[4], s[8]};
   endfunction

   initial begin
      #40000;
      errors++;
      report_and_stop;
   end

   initial begin
      req = '0;
      ev = 4'h0;
      nrst = 1'b0;
      bank = 5'h00;
      fl = FLAGS_RST;
      ta = '{8'h0F, 8'hFF, 8'h05, 8'h00, 8'h80};
      tv = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h80};
      to = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_ADD};
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(21'(flags_q), 21'(FLAGS_RST), "reset flags");
      rd(OFS_FLAGS, FLAGS_RST);
      for (int i = 0; i < 8; i++) begin
         bk[i] = 5'(i * 4 + $unsigned($random(seed)) % 4);
         dv[i] = 8'($random(seed));
         acc(1'b1, 1'b0, 1'b0, OFS_BSEL, {3'b000, bk[i]});
         acc(1'b1, 1'b0, 1'b0, 7'h40, dv[i]);
      end
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, 1'b0, 1'b0, OFS_BSEL, {3'b000, bk[i]});
         rd(7'h40, dv[i]);
      end
      acc(1'b1, 1'b0, 1'b0, OFS_BSEL, 8'h03);
      acc(1'b1, 1'b0, 1'b0, 7'h7F, 8'hC5);
      acc(1'b1, 1'b0, 1'b0, OFS_ACC, 8'hA7);
      acc(1'b1, 1'b0, 1'b0, OFS_BSEL, 8'h16);
      rd(7'h7F, 8'hC5);
      rd(OFS_ACC, 8'hA7);
      rd(OFS_BSEL, 8'h16);
      acc(1'b0, 1'b0, 1'b0, OFS_SFR_LO, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_SFR_HI, 8'h9B);
      acc(1'b1, 1'b0, 1'b0, OFS_P0H, {3'b000, bk[2]});
      acc(1'b1, 1'b0, 1'b0, OFS_P0L, 8'h40);
      rq.push_back(dv[2]);
      acc(1'b0, 1'b1, 1'b0, OFS_INDIRECT_DATA_ZERO, 8'h00);
      acc(1'b1, 1'b0, 1'b0, OFS_P0H, 8'h02);
      acc(1'b1, 1'b0, 1'b0, OFS_P0L, 8'h15);
      sq.push_back({1'b0, 5'h02, 7'h15, 8'h00});
      acc(1'b0, 1'b1, 1'b0, OFS_INDIRECT_DATA_ZERO, 8'h00);
      hi = sfr_rdata;
      rd(OFS_ACC, hi);
      for (int i = 0; i < 3; i++) begin
         hi = 8'h80 | 8'($random(seed));
         lo = 8'($random(seed));
         acc(1'b1, 1'b0, 1'b0, OFS_P1H, hi);
         acc(1'b1, 1'b0, 1'b0, OFS_P1L, lo);
         pw = pm_word({hi[6:0], lo});
         rq.push_back(pw[7:0]);
         acc(1'b0, 1'b1, 1'b1, OFS_INDIRECT_DATA_ONE, 8'h00);
         req <= '0;
         @(posedge clk);
         chk(21'({busy_q, rvalid_q, pm_rd_q}), 21'h5, "pm wait");
         rd(OFS_ACC, pw[7:0]);
      end
      acc(1'b1, 1'b0, 1'b0, OFS_BSEL, 8'h01);
      acc(1'b1, 1'b0, 1'b0, 7'h30, 8'h3C);
      acc(1'b1, 1'b0, 1'b0, OFS_P1H, 8'h81);
      acc(1'b1, 1'b0, 1'b0, OFS_P1L, 8'h30);
      acc(1'b1, 1'b1, 1'b1, OFS_INDIRECT_DATA_ONE, 8'hC3);
      rd(7'h30, 8'h3C);
      for (int i = 0; i < 12; i++) begin
         if (i < 5) begin
            hi = ta[i];
            lo = tv[i];
         end else begin
            hi = 8'($random(seed));
            lo = 8'($random(seed));
         end
         if (i == 11) {hi, lo} = 16'h0000;
         if (i >= 5) to[0] = (i == 11) ? ALU_LOGIC : ((i % 2) ? ALU_SUB : ALU_ADD);
         fl = alu(fl, (i < 5) ? to[i] : to[0], hi, lo);
         acc(1'b1, 1'b0, 1'b0, 7'h6F, 8'h00, (i < 5) ? to[i] : to[0], hi, lo);
         rd(OFS_FLAGS, fl);
      end
      fl = alu(fl, ALU_ADD, 8'hFF, 8'h01);
      acc(1'b1, 1'b0, 1'b0, OFS_FLAGS, 8'h00, ALU_ADD, 8'hFF, 8'h01);
      rd(OFS_FLAGS, fl);
      fl = {3'b000, fl[4:3], 3'b010};
      acc(1'b1, 1'b0, 1'b0, OFS_FLAGS, 8'hE2);
      rd(OFS_FLAGS, fl);
      pulse(4'b0010);
      fl[4:3] = 2'b10;
      rd(OFS_FLAGS, fl);
      pulse(4'b0001);
      fl[4] = 1'b0;
      rd(OFS_FLAGS, fl);
      pulse(4'b0100);
      fl[4:3] = 2'b11;
      rd(OFS_FLAGS, fl);
      pulse(4'b0001);
      pulse(4'b1000);
      rd(OFS_FLAGS, FLAGS_RST);
      req <= '0;
      repeat (4) @(posedge clk);
      chk(21'(rq.size() + sq.size()), 21'h0, "pending notes");
      report_and_stop;
   end
endmodule
`default_nettype wire
